// ---- verilog/fsg_gateway.sv ----
// fsg_gateway: block-transfer engine between a serial port and a fieldbus slave memory.
// assumes the serial driver and the fieldbus slave framing sit outside, speaking
// word-level handshakes; all inputs except the asynchronous reset rst_b are synchronous to clk.
module fsg_gateway #(
	parameter int DL_CYCLES = fsg_pkg::DL_WINDOW_CYC,
	parameter int BLINK_CYCLES = fsg_pkg::BLINK_CYC,
	parameter int FIFO_DEPTH = fsg_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ser_is_master,
	input wire logic dev_present,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_index,
	input wire logic cfg_dir,
	input wire logic [7:0] cfg_count,
	input wire logic [15:0] cfg_ser_addr,
	input wire logic [15:0] cfg_gw_addr,
	input wire logic cfg_num_wr,
	input wire logic [7:0] cfg_num_blocks,
	input wire logic cfg_rate_wr,
	input wire logic [fsg_pkg::RATE_W-1:0] cfg_ser_baud,
	input wire logic [fsg_pkg::RATE_W-1:0] cfg_fb_bps,
	output logic cfg_accept,
	output logic cfg_reject,
	output logic download_mode,
	output logic status_indicator,
	input wire logic ctl_enable,
	input wire logic [fsg_pkg::MAX_BLOCKS-1:0] ctl_bits,
	output logic ser_req_valid,
	input wire logic ser_req_ready,
	output logic ser_req_we,
	output logic [15:0] ser_req_addr,
	output logic [fsg_pkg::WORD_W-1:0] ser_req_wdata,
	input wire logic ser_rsp_valid,
	input wire logic [fsg_pkg::WORD_W-1:0] ser_rsp_rdata,
	input wire logic fb_req,
	input wire logic fb_we,
	input wire logic [6:0] fb_addr,
	input wire logic [fsg_pkg::WORD_W-1:0] fb_wdata,
	output logic fb_ack,
	output logic [fsg_pkg::WORD_W-1:0] fb_rdata,
	output logic [fsg_pkg::RATE_W-1:0] ser_baud,
	output logic [fsg_pkg::RATE_W-1:0] fb_bps,
	output logic running,
	output logic [7:0] cur_block
);
	localparam int W = fsg_pkg::WORD_W;
	localparam int TW = fsg_pkg::TMR_W;
	localparam int RATE_W = fsg_pkg::RATE_W;

	// gateway word address to shared memory index; input area sits above output area
	function automatic logic [7:0] gw_index(input logic [15:0] gw);
		logic [15:0] off;
		off = (gw >= fsg_pkg::IN_BASE) ? gw - fsg_pkg::IN_BASE : gw - fsg_pkg::OUT_BASE;
		gw_index = (gw >= fsg_pkg::IN_BASE) ? 8'(off) + 8'(fsg_pkg::AREA_WORDS) : 8'(off);
	endfunction : gw_index

	// true when count words starting at gw lie inside one area
	function automatic logic gw_span_ok(input logic [15:0] gw, input logic [7:0] cnt);
		logic [16:0] base;
		logic [16:0] last;
		base = (gw >= fsg_pkg::IN_BASE) ? {1'b0, gw - fsg_pkg::IN_BASE} : {1'b0, gw};
		last = base + {9'h000, cnt};
		gw_span_ok = (cnt != 8'h00) && (last <= 17'(fsg_pkg::AREA_WORDS));
	endfunction : gw_span_ok

	// block table, written only during download
	logic tbl_dir [fsg_pkg::MAX_BLOCKS];
	logic [7:0] tbl_cnt [fsg_pkg::MAX_BLOCKS];
	logic [15:0] tbl_ser [fsg_pkg::MAX_BLOCKS];
	logic [15:0] tbl_gw [fsg_pkg::MAX_BLOCKS];

	logic [W-1:0] mem_q [fsg_pkg::MEM_WORDS];
	logic [W-1:0] mem_rd_q, mem_rd_d;

	fsg_pkg::fsg_state_e state_q, state_d;
	logic [7:0] blk_q, blk_d, num_q, num_d;
	logic [8:0] fetch_q, fetch_d, store_q, store_d;
	logic [7:0] foff_q, foff_d, soff_q, soff_d;
	logic ser_busy_q, ser_busy_d, rd_pend_q, rd_pend_d;
	logic [TW-1:0] dl_q, dl_d, blink_cnt_q, blink_cnt_d;
	logic blink_q, blink_d, led_q, led_d;
	logic acc_q, acc_d, rej_q, rej_d;
	logic [fsg_pkg::RATE_W-1:0] sbaud_q, sbaud_d, fbps_q, fbps_d;
	logic ack_q, ack_d, prio_fb_q, prio_fb_d;

	logic b_dir;
	logic [15:0] b_ser, b_gw;
	logic [7:0] blk_next;
	logic in_dl, tbl_we, blk_done;
	logic eng_req, eng_we, eng_gnt, fb_gnt;
	logic [7:0] eng_idx, fb_idx;
	logic [W-1:0] eng_wdata;
	logic fi_valid, fi_ready, fo_valid, fo_ready;
	logic [W-1:0] fi_data, fo_data;

	assign b_dir = tbl_dir[blk_q];
	assign b_ser = tbl_ser[blk_q];
	assign b_gw = tbl_gw[blk_q];
	assign in_dl = (state_q == fsg_pkg::ST_DOWNLOAD);
	assign blk_next = (blk_q + 8'h01 >= num_q) ? 8'h00 : blk_q + 8'h01;

	// configuration only while the serial download window is open
	assign tbl_we = cfg_wr && in_dl && (cfg_index < 8'(fsg_pkg::MAX_BLOCKS))
		&& gw_span_ok(cfg_gw_addr, cfg_count);

	always_ff @(posedge clk) begin
		if (tbl_we) begin
			tbl_dir[cfg_index] <= cfg_dir;
			tbl_cnt[cfg_index] <= cfg_count;
			tbl_ser[cfg_index] <= cfg_ser_addr;
			tbl_gw[cfg_index] <= cfg_gw_addr;
		end
	end

	// data path fifo: source words in, destination words out
	fsg_fifo #(
		.WIDTH(W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(fi_valid),
		.in_ready(fi_ready),
		.in_data(fi_data),
		.out_valid(fo_valid),
		.out_ready(fo_ready),
		.out_data(fo_data)
	);

	// engine side of the shared memory
	always_comb begin
		eng_req = 1'b0;
		eng_we = 1'b0;
		eng_idx = gw_index(b_gw + {8'h00, foff_q});
		eng_wdata = fo_data;
		ser_req_valid = 1'b0;
		ser_req_we = 1'b0;
		ser_req_addr = b_ser + {8'h00, foff_q};
		fi_valid = 1'b0;
		fi_data = ser_rsp_rdata;
		fo_ready = 1'b0;
		if (state_q == fsg_pkg::ST_RUN) begin
			if (b_dir == fsg_pkg::DIR_TO_FB) begin
				// serial read into fifo, fifo into input area
				ser_req_valid = (fetch_q != 9'h000) && !ser_busy_q && fi_ready;
				fi_valid = ser_rsp_valid && ser_busy_q;
				eng_req = fo_valid;
				eng_we = 1'b1;
				eng_idx = gw_index(b_gw + {8'h00, soff_q});
				fo_ready = eng_gnt;
			end else begin
				// output area into fifo, fifo out as serial writes
				eng_req = (fetch_q != 9'h000) && !rd_pend_q && fi_ready;
				fi_valid = rd_pend_q;
				fi_data = mem_rd_q;
				ser_req_valid = fo_valid && !ser_busy_q;
				ser_req_we = 1'b1;
				ser_req_addr = b_ser + {8'h00, soff_q};
				fo_ready = ser_req_ready && !ser_busy_q;
			end
		end
	end
	assign ser_req_wdata = fo_data;

	// fieldbus master: writes reach only the output area, reads only the input area
	assign fb_idx = fb_we ? 8'(fb_addr) : 8'(fb_addr) + 8'(fsg_pkg::AREA_WORDS);

	// alternating priority; one whole word per grant
	assign fb_gnt = fb_req && !ack_q && (!eng_req || prio_fb_q);
	assign eng_gnt = eng_req && !fb_gnt;

	always_comb begin
		mem_rd_d = mem_rd_q;
		ack_d = fb_gnt;
		prio_fb_d = prio_fb_q;
		if (fb_gnt) begin
			prio_fb_d = 1'b0;
			mem_rd_d = (fb_we || fb_addr >= 7'(fsg_pkg::AREA_WORDS)) ? '0 : mem_q[fb_idx];
		end else if (eng_gnt) begin
			prio_fb_d = 1'b1;
			mem_rd_d = mem_q[eng_idx];
		end
	end

	always_ff @(posedge clk) begin
		if (fb_gnt && fb_we && fb_addr < 7'(fsg_pkg::AREA_WORDS)) begin
			mem_q[fb_idx] <= fb_wdata;
		end else if (eng_gnt && eng_we) begin
			mem_q[eng_idx] <= eng_wdata;
		end
	end

	assign blk_done = (fetch_q == 9'h000) && (store_q == 9'h000) && !ser_busy_q && !rd_pend_q;

	// sequencer, download window and indicator
	always_comb begin
		state_d = state_q;
		blk_d = blk_q;
		num_d = num_q;
		fetch_d = fetch_q;
		store_d = store_q;
		foff_d = foff_q;
		soff_d = soff_q;
		ser_busy_d = ser_busy_q;
		rd_pend_d = 1'b0;
		dl_d = dl_q;
		blink_cnt_d = blink_cnt_q;
		blink_d = blink_q;
		acc_d = 1'b0;
		rej_d = 1'b0;
		sbaud_d = sbaud_q;
		fbps_d = fbps_q;
		case (state_q)
			fsg_pkg::ST_BOOT: begin
				dl_d = '0;
				state_d = ser_is_master ? fsg_pkg::ST_PROBE : fsg_pkg::ST_DOWNLOAD;
			end
			fsg_pkg::ST_PROBE: begin
				dl_d = '0;
				state_d = dev_present ? fsg_pkg::ST_SELECT : fsg_pkg::ST_DOWNLOAD;
			end
			fsg_pkg::ST_DOWNLOAD: begin
				if (dl_q == TW'(DL_CYCLES - 1)) begin
					dl_d = '0;
					// master retries the probe, slave gets one window only
					state_d = ser_is_master ? fsg_pkg::ST_PROBE : fsg_pkg::ST_SELECT;
				end else begin
					dl_d = dl_q + 1'b1;
				end
				if (blink_cnt_q == TW'(BLINK_CYCLES - 1)) begin
					blink_cnt_d = '0;
					blink_d = !blink_q;
				end else begin
					blink_cnt_d = blink_cnt_q + 1'b1;
				end
			end
			fsg_pkg::ST_SELECT: begin
				blk_d = (blk_q >= num_q) ? 8'h00 : blk_q;
				if (num_q != 8'h00 && blk_q < num_q) begin
					if (!ctl_enable || ctl_bits[blk_q]) begin
						fetch_d = {1'b0, tbl_cnt[blk_q]};
						store_d = {1'b0, tbl_cnt[blk_q]};
						foff_d = 8'h00;
						soff_d = 8'h00;
						state_d = fsg_pkg::ST_RUN;
					end else begin
						blk_d = blk_next;
					end
				end
			end
			fsg_pkg::ST_RUN: begin
				if (ser_req_valid && ser_req_ready) begin
					ser_busy_d = 1'b1;
				end
				if (ser_rsp_valid && ser_busy_q) begin
					ser_busy_d = 1'b0;
				end
				if (b_dir == fsg_pkg::DIR_TO_FB) begin
					if (ser_req_valid && ser_req_ready) begin
						fetch_d = fetch_q - 9'h001;
						foff_d = foff_q + 8'h01;
					end
					if (eng_gnt) begin
						store_d = store_q - 9'h001;
						soff_d = soff_q + 8'h01;
					end
				end else begin
					if (eng_gnt) begin
						rd_pend_d = 1'b1;
						fetch_d = fetch_q - 9'h001;
						foff_d = foff_q + 8'h01;
					end
					if (ser_req_valid && ser_req_ready) begin
						store_d = store_q - 9'h001;
						soff_d = soff_q + 8'h01;
					end
				end
				if (blk_done) begin
					blk_d = blk_next;
					state_d = fsg_pkg::ST_SELECT;
				end
			end
			default: begin
				state_d = fsg_pkg::ST_BOOT;
			end
		endcase
		if (cfg_wr) begin
			acc_d = tbl_we;
			rej_d = !tbl_we;
		end else if (cfg_num_wr) begin
			acc_d = in_dl && cfg_num_blocks <= 8'(fsg_pkg::MAX_BLOCKS);
			rej_d = !acc_d;
			num_d = acc_d ? cfg_num_blocks : num_q;
		end else if (cfg_rate_wr) begin
			acc_d = in_dl
				&& cfg_ser_baud >= RATE_W'(fsg_pkg::SER_MIN_BAUD)
				&& cfg_ser_baud <= RATE_W'(fsg_pkg::SER_MAX_BAUD)
				&& cfg_fb_bps >= RATE_W'(fsg_pkg::FB_MIN_BPS)
				&& cfg_fb_bps <= RATE_W'(fsg_pkg::FB_MAX_BPS);
			rej_d = !acc_d;
			sbaud_d = acc_d ? cfg_ser_baud : sbaud_q;
			fbps_d = acc_d ? cfg_fb_bps : fbps_q;
		end
		led_d = (state_d == fsg_pkg::ST_DOWNLOAD) ? blink_d : (state_d != fsg_pkg::ST_BOOT);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= fsg_pkg::ST_BOOT;
			blk_q <= 8'h00;
			num_q <= 8'h00;
			fetch_q <= 9'h000;
			store_q <= 9'h000;
			foff_q <= 8'h00;
			soff_q <= 8'h00;
			ser_busy_q <= 1'b0;
			rd_pend_q <= 1'b0;
			dl_q <= '0;
			blink_cnt_q <= '0;
			blink_q <= 1'b0;
			led_q <= 1'b0;
			acc_q <= 1'b0;
			rej_q <= 1'b0;
			sbaud_q <= fsg_pkg::SER_BAUD_RST;
			fbps_q <= fsg_pkg::FB_BPS_RST;
			ack_q <= 1'b0;
			prio_fb_q <= 1'b1;
			mem_rd_q <= '0;
		end else begin
			state_q <= state_d;
			blk_q <= blk_d;
			num_q <= num_d;
			fetch_q <= fetch_d;
			store_q <= store_d;
			foff_q <= foff_d;
			soff_q <= soff_d;
			ser_busy_q <= ser_busy_d;
			rd_pend_q <= rd_pend_d;
			dl_q <= dl_d;
			blink_cnt_q <= blink_cnt_d;
			blink_q <= blink_d;
			led_q <= led_d;
			acc_q <= acc_d;
			rej_q <= rej_d;
			sbaud_q <= sbaud_d;
			fbps_q <= fbps_d;
			ack_q <= ack_d;
			prio_fb_q <= prio_fb_d;
			mem_rd_q <= mem_rd_d;
		end
	end

	assign cfg_accept = acc_q;
	assign cfg_reject = rej_q;
	assign download_mode = in_dl;
	assign status_indicator = led_q;
	assign fb_ack = ack_q;
	assign fb_rdata = mem_rd_q;
	assign ser_baud = sbaud_q;
	assign fb_bps = fbps_q;
	assign running = (state_q == fsg_pkg::ST_RUN);
	assign cur_block = blk_q;
endmodule : fsg_gateway

// ---- verilog/fsg_pkg.sv ----
// fsg_pkg: shared constants for the fieldbus/serial block gateway.
// assumes a single 25 MHz clock and an asynchronous active-low reset.
// Summary of operation
// - 100-word input and output shared areas
// - input area at 1000, output area at 0000
// - blocks move serial words to/from areas
// - engine and fieldbus master both access memory
// - serial port initiates; attached devices only respond
// - ungated blocks run continuously, word count each
// - one block at a time, first to last
// - after last block restart at first, forever
// - gating on: run only selected blocks
// - at most 255 configured blocks
// - word count sets words read and written
// - indicator blinks while in download mode
// - serial master: probe device, else listen 10sec
// - serial slave: single 10sec download window
// - downloads only through the serial port
// - fieldbus 9.6K-12M, serial 300-115.2K baud
package fsg_pkg;
	localparam int WORD_W = 16;
	localparam int AREA_WORDS = 100;
	localparam int MEM_WORDS = 2 * AREA_WORDS;
	localparam logic [15:0] IN_BASE = 16'h1000;
	localparam logic [15:0] OUT_BASE = 16'h0000;
	localparam int MAX_BLOCKS = 255;
	localparam int FIFO_DEPTH = 4;

	localparam logic DIR_TO_FB = 1'b0;
	localparam logic DIR_FROM_FB = 1'b1;

	localparam int CLK_HZ = 25_000_000;
	localparam int DL_WINDOW_MS = 10_000;
	localparam int DL_WINDOW_CYC = CLK_HZ / 1000 * DL_WINDOW_MS;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
	localparam int TMR_W = 28;

	localparam int FB_MIN_BPS = 9_600;
	localparam int FB_MAX_BPS = 12_000_000;
	localparam int SER_MIN_BAUD = 300;
	localparam int SER_MAX_BAUD = 115_200;
	localparam int RATE_W = 24;
	localparam logic [RATE_W-1:0] SER_BAUD_RST = 24'h002580;
	localparam logic [RATE_W-1:0] FB_BPS_RST = 24'h002580;

	typedef enum logic [2:0] {
		ST_BOOT,
		ST_PROBE,
		ST_DOWNLOAD,
		ST_SELECT,
		ST_RUN
	} fsg_state_e;
endpackage : fsg_pkg

// ---- verilog/fsg_fifo.sv ----
// fsg_fifo: small synchronous fifo with valid/ready on both sides.
// assumes one clock; out_data is the head word and is valid with out_valid.
module fsg_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic push, pop;

	assign in_ready = (cnt_q != CW'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
		end
		if (pop) begin
			rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end
endmodule : fsg_fifo

// ---- dv/fsg_gateway_props.sv ----
// fsg_gateway_props: port-level assertions for the block gateway.
// assumes a bind onto fsg_gateway; one clock, async active-low reset.
module fsg_gateway_props #(
	parameter int DL_CYCLES = 200,
	parameter int BLINK_CYCLES = 10
) (
	input logic clk,
	input logic rst_b,
	input logic cfg_wr,
	input logic cfg_num_wr,
	input logic cfg_rate_wr,
	input logic cfg_accept,
	input logic cfg_reject,
	input logic download_mode,
	input logic status_indicator,
	input logic ser_req_valid,
	input logic ser_req_ready,
	input logic [15:0] ser_req_addr,
	input logic ser_rsp_valid,
	input logic fb_req,
	input logic fb_we,
	input logic [6:0] fb_addr,
	input logic fb_ack,
	input logic [15:0] fb_rdata,
	input logic running
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	logic [31:0] dl_q;
	logic [31:0] led_q;
	logic led_prev_q;
	logic busy_q;
	// window length, cycles since last indicator change, serial request outstanding
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dl_q <= '0;
			led_q <= '0;
			led_prev_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			dl_q <= download_mode ? dl_q + 32'h1 : '0;
			led_q <= (!download_mode || status_indicator != led_prev_q) ? '0 : led_q + 32'h1;
			led_prev_q <= status_indicator;
			busy_q <= (busy_q && !ser_rsp_valid) || (ser_req_valid && ser_req_ready);
		end
	end
	chk_fb_ack_pulse: assert property (fb_ack |=> !fb_ack)
		else $error("fb_ack held too long");
	chk_fb_ack_time: assert property (fb_req && !fb_ack |-> ##[1:2] fb_ack)
		else $error("fb_ack late");
	chk_fb_oob_zero: assert property (fb_req && !fb_ack && !fb_we && fb_addr >= 7'h64
		|-> ##[1:2] (fb_ack && fb_rdata == 16'h0000))
		else $error("out of area read not zero");
	chk_cfg_answer: assert property (cfg_wr || cfg_num_wr || cfg_rate_wr
		|=> cfg_accept != cfg_reject)
		else $error("config answer missing");
	chk_cfg_quiet: assert property (!(cfg_wr || cfg_num_wr || cfg_rate_wr)
		|=> !cfg_accept && !cfg_reject)
		else $error("config answer unprompted");
	chk_dl_window: assert property (download_mode |-> dl_q <= DL_CYCLES)
		else $error("download window too long");
	chk_led_blink: assert property (download_mode |-> led_q <= BLINK_CYCLES + 1)
		else $error("indicator not blinking");
	chk_led_run: assert property (running |-> status_indicator && !download_mode)
		else $error("indicator or mode wrong while running");
	chk_ser_hold: assert property (ser_req_valid && !ser_req_ready
		|=> ser_req_valid && $stable(ser_req_addr))
		else $error("serial request dropped");
	chk_ser_single: assert property (busy_q |-> !ser_req_valid)
		else $error("second serial request outstanding");
	cover property (ser_req_valid && !ser_req_ready);
	cover property (running && fb_ack);
	cover property ($fell(download_mode));
endmodule : fsg_gateway_props

bind fsg_gateway fsg_gateway_props #(.DL_CYCLES(DL_CYCLES), .BLINK_CYCLES(BLINK_CYCLES))
	fsg_gateway_props_i (.clk, .rst_b, .cfg_wr, .cfg_num_wr, .cfg_rate_wr, .cfg_accept,
	.cfg_reject, .download_mode, .status_indicator, .ser_req_valid, .ser_req_ready,
	.ser_req_addr, .ser_rsp_valid, .fb_req, .fb_we, .fb_addr, .fb_ack, .fb_rdata, .running);

// ---- dv/fsg_ser_dev.sv ----
// fsg_ser_dev: serial device model, answers word requests lat+1 cycles after acceptance.
// assumes one request at a time; read data is a fixed pattern until written.
module fsg_ser_dev (
	input logic clk,
	input logic rst_b,
	input logic [3:0] lat,
	input logic req_valid,
	output logic req_ready,
	input logic req_we,
	input logic [15:0] req_addr,
	input logic [15:0] req_wdata,
	output logic rsp_valid,
	output logic [15:0] rsp_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [256];
	logic busy;
	logic seen;
	logic [3:0] cnt;
	logic [7:0] addr;
	initial for (int i = 0; i < 256; i++) mem[i] = 16'ha500 ^ 16'(i);
	// slow mode stalls ready one cycle; the device never starts a transfer
	assign req_ready = !busy && (lat == 4'h0 || seen);
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{busy, seen, rsp_valid} <= 3'h0;
			rsp_rdata <= 16'hffff;
		end else begin
			seen <= req_valid && !busy && !req_ready;
			rsp_valid <= busy && cnt == 4'h0;
			// off the response cycle the data lines carry the previous value inverted
			rsp_rdata <= (busy && cnt == 4'h0) ? mem[addr] : ~rsp_rdata;
			if (busy) begin
				busy <= cnt != 4'h0;
				cnt <= cnt - 4'h1;
			end else if (req_valid && req_ready) begin
				busy <= 1'b1;
				cnt <= lat;
				addr <= req_addr[7:0];
				if (req_we) mem[req_addr[7:0]] <= req_wdata;
			end
		end
	end
endmodule : fsg_ser_dev

// ---- dv/tb_fsg_gateway.sv ----
// tb_fsg_gateway: self-checking bench for the block gateway.
// assumes fsg_ser_dev on the serial port and short window and blink counts.
module tb_fsg_gateway;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DL = 200;
	localparam int BL = 10;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic ser_is_master = 1'b0, dev_present = 1'b0, ctl_enable = 1'b0, cfg_dir = 1'b0;
	logic cfg_wr = 1'b0, cfg_num_wr = 1'b0, cfg_rate_wr = 1'b0, fb_req = 1'b0, fb_we = 1'b0;
	logic [7:0] cfg_index = '0, cfg_count = '0, cfg_num_blocks = '0, cur_block;
	logic [15:0] cfg_ser_addr = '0, cfg_gw_addr = '0, fb_wdata = '0, rd;
	logic [23:0] cfg_ser_baud = '0, cfg_fb_bps = '0, ser_baud, fb_bps;
	logic [254:0] ctl_bits = '0;
	logic [6:0] fb_addr = '0;
	logic [3:0] lat = 4'h0;
	logic cfg_accept, cfg_reject, download_mode, status_indicator, running, fb_ack;
	logic ser_req_valid, ser_req_ready, ser_req_we, ser_rsp_valid;
	logic [15:0] ser_req_addr, ser_req_wdata, ser_rsp_rdata, fb_rdata;
	int num_errors = 0, num_checks = 0, cyc = 0, since = 0;
	always #20 clk = ~clk;
	fsg_gateway #(.DL_CYCLES(DL), .BLINK_CYCLES(BL), .FIFO_DEPTH(4)) fsg_gateway_i (.clk, .rst_b,
		.ser_is_master, .dev_present, .cfg_wr, .cfg_index, .cfg_dir, .cfg_count, .cfg_ser_addr,
		.cfg_gw_addr, .cfg_num_wr, .cfg_num_blocks, .cfg_rate_wr, .cfg_ser_baud, .cfg_fb_bps,
		.cfg_accept, .cfg_reject, .download_mode, .status_indicator, .ctl_enable, .ctl_bits,
		.ser_req_valid, .ser_req_ready, .ser_req_we, .ser_req_addr, .ser_req_wdata,
		.ser_rsp_valid, .ser_rsp_rdata, .fb_req, .fb_we, .fb_addr, .fb_wdata, .fb_ack,
		.fb_rdata, .ser_baud, .fb_bps, .running, .cur_block);
	fsg_ser_dev fsg_ser_dev_i (.clk, .rst_b, .lat, .req_valid(ser_req_valid),
		.req_ready(ser_req_ready), .req_we(ser_req_we), .req_addr(ser_req_addr),
		.req_wdata(ser_req_wdata), .rsp_valid(ser_rsp_valid), .rsp_rdata(ser_rsp_rdata));
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out
	always @(posedge clk) begin
		cyc <= cyc + 1;
		since <= rst_b ? since + 1 : 0;
		if (cyc == 20000) begin
			num_errors++;
			$display("CHECK FAILED run time expected 20000 seen more");
			close_out();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// run selects the running output, otherwise download_mode is watched
	task automatic wait_lvl(input string what, input logic run, input logic lvl, input int lim);
		int n = 0;
		while ((run ? running : download_mode) !== lvl && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(what, lvl, run ? running : download_mode);
	endtask : wait_lvl
	task automatic cfg(input logic [2:0] str, input logic ok);
		{cfg_rate_wr, cfg_num_wr, cfg_wr} <= str;
		@(posedge clk);
		{cfg_rate_wr, cfg_num_wr, cfg_wr} <= 3'h0;
		@(posedge clk);
		chk("cfg_accept", ok, cfg_accept);
		chk("cfg_reject", !ok, cfg_reject);
	endtask : cfg
	task automatic blk(input logic [7:0] i, n, input logic d, input logic [15:0] sa, ga,
		input logic ok);
		{cfg_index, cfg_dir, cfg_count, cfg_ser_addr, cfg_gw_addr} <= {i, d, n, sa, ga};
		cfg(3'h1, ok);
	endtask : blk
	task automatic fb(input logic we, input logic [6:0] a, input logic [15:0] wd);
		int n = 0;
		@(posedge clk);
		{fb_req, fb_we, fb_addr, fb_wdata} <= {1'b1, we, a, wd};
		do begin
			@(posedge clk);
			n++;
		end while (fb_ack !== 1'b1 && n < 8);
		rd = fb_rdata;
		fb_req <= 1'b0;
		chk("fb_ack", 1'b1, fb_ack);
	endtask : fb
	task automatic t_download();
		int t = 0;
		logic prev;
		chk("download_mode", 1'b1, download_mode);
		repeat (4 * BL) begin
			prev = status_indicator;
			@(posedge clk);
			if (status_indicator !== prev) t++;
		end
		chk("blinks", 1'b1, t >= 3 && t <= 5);
		fb(1'b1, 7'h02, 16'h1234);
		fb(1'b1, 7'h03, 16'hbeef);
		fb(1'b1, 7'h05, 16'h7777);
		blk(8'h00, 8'h03, 1'b0, 16'h0010, 16'h1005, 1'b1);
		blk(8'h01, 8'h02, 1'b1, 16'h0040, 16'h0002, 1'b1);
		blk(8'h02, 8'h00, 1'b0, 16'h0020, 16'h1000, 1'b0);
		blk(8'hff, 8'h01, 1'b0, 16'h0020, 16'h1000, 1'b0);
		blk(8'h02, 8'h02, 1'b0, 16'h0020, 16'h1063, 1'b0);
		blk(8'h02, 8'h01, 1'b1, 16'h0020, 16'h0063, 1'b1);
		cfg_num_blocks <= 8'h02;
		cfg(3'h2, 1'b1);
		{cfg_ser_baud, cfg_fb_bps} <= {24'h00012b, 24'h002580};
		cfg(3'h4, 1'b0);
		{cfg_ser_baud, cfg_fb_bps} <= {24'h00012c, 24'h00257f};
		cfg(3'h4, 1'b0);
		{cfg_ser_baud, cfg_fb_bps} <= {24'h01c200, 24'hb71b00};
		cfg(3'h4, 1'b1);
		chk("ser_baud", 24'h01c200, ser_baud);
		chk("fb_bps", 24'hb71b00, fb_bps);
		wait_lvl("window end", 1'b0, 1'b0, DL);
		chk("window length", 1'b1, since >= DL - 2 && since <= DL + 3);
		blk(8'h03, 8'h01, 1'b0, 16'h0020, 16'h1000, 1'b0);
	endtask : t_download
	task automatic t_run();
		int t = 0;
		wait_lvl("running", 1'b1, 1'b1, 20);
		rd[7:0] = cur_block;
		repeat (150) begin
			@(posedge clk);
			if (cur_block !== rd[7:0]) begin
				chk("next block", (rd[7:0] + 8'h1) % 8'h2, cur_block);
				rd[7:0] = cur_block;
				t++;
			end
		end
		chk("cycles repeat", 1'b1, t >= 2);
		chk("dev 40", 16'h1234, fsg_ser_dev_i.mem[8'h40]);
		chk("dev 41", 16'hbeef, fsg_ser_dev_i.mem[8'h41]);
		chk("dev 42", 16'ha542, fsg_ser_dev_i.mem[8'h42]);
		for (int k = 0; k < 3; k++) begin
			fb(1'b0, 7'(5 + k), 16'h0000);
			chk("input area", 16'ha510 + 16'(k), rd);
		end
		fb(1'b0, 7'h64, 16'h0000);
		chk("outside area", 16'h0000, rd);
		fb(1'b1, 7'h02, 16'h4321);
		repeat (150) @(posedge clk);
		chk("dev 40 again", 16'h4321, fsg_ser_dev_i.mem[8'h40]);
	endtask : t_run
	task automatic t_gate();
		{ctl_enable, ctl_bits, lat} <= {1'b1, 255'h1, 4'h5};
		repeat (60) @(posedge clk);
		fb(1'b1, 7'h02, 16'h5a5a);
		repeat (200) @(posedge clk);
		chk("gated off", 16'h4321, fsg_ser_dev_i.mem[8'h40]);
		ctl_bits <= 255'h2;
		repeat (200) @(posedge clk);
		chk("gated on", 16'h5a5a, fsg_ser_dev_i.mem[8'h40]);
	endtask : t_gate
	task automatic t_master();
		{rst_b, ser_is_master, ctl_enable} <= 3'b010;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		wait_lvl("listen", 1'b0, 1'b1, 10);
		wait_lvl("listen end", 1'b0, 1'b0, DL + 5);
		wait_lvl("listen again", 1'b0, 1'b1, 10);
		// reset cleared the block count; the block table itself is kept
		cfg(3'h2, 1'b1);
		dev_present <= 1'b1;
		wait_lvl("device found", 1'b1, 1'b1, DL + 10);
		chk("no download", 1'b0, download_mode);
	endtask : t_master
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		t_download();
		t_run();
		t_gate();
		t_master();
		close_out();
	end
endmodule : tb_fsg_gateway
